// ==== design/irqpe_core.sv ====
// Interrupt arbitration and external request detection.
// Assumes the sequencer reports each instruction end in one cycle and
// that software reaches the registers over APB with 8-bit addresses.
// What this block does
// - Bypass bit seven of priority register disables priority; enables alone govern.
// - In bypass mode a nested request is taken whenever its enable is set.
// - Equal priority ties resolve ext0, timer0, ext1, timer1, serial, timer2.
// - All priority bits clear gives one level; no preemption of a routine.
// - All priority bits set behaves exactly like all clear.
// - Bits 0 and 2 of timer control select level or falling edge.
// - Level mode samples pin at phase five, copies to flag at phase three.
// - Level mode clears the request flag at phase six every machine cycle.
// - Edge mode two-stage latch differencing sets a set/reset flip-flop.
// - Edge flip-flop sets flag at second-cycle phase three, clears at phase four.
// - Edge mode ignores requests until the first stage has seen pin high.
// - After an ordinary instruction the vector call starts the next cycle.
// - After an enable or priority write, vector only after one more instruction.
// - Merely copying enable or priority registers adds no delay.
// - After return from interrupt, exactly one instruction runs before vectoring.
// - If that instruction writes enable or priority, two instructions run first.
// - With priority active, a high request suspends a low routine.
// - Global enable clear blocks every interrupt entry.
module irqpe_core #(
  parameter int PHASE_CLKS = irqpe_pkg::PHASE_CLKS
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               ext0Pin,
  input  wire logic               ext1Pin,
  input  wire logic               timer0Req,
  input  wire logic               timer1Req,
  input  wire logic               serialReq,
  input  wire logic               timer2Req,
  input  wire irqpe_pkg::irqpe_seq_t seq,
  output irqpe_pkg::irqpe_vec_t   vec,
  output logic [1:0]              inService
);

  // Returns {found, index} of the lowest set bit: lowest index wins ties
  function automatic logic [3:0] pickFirst(input logic [5:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int k = irqpe_pkg::NUM_SRC - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = {1'b1, 3'(k)};
      end
    end
    return r;
  endfunction

  // Arbitration index of external input i: each pin sits just ahead of its timer
  function automatic logic [2:0] extSrc(input int i);
    return 3'(i * irqpe_pkg::EXT_STRIDE);
  endfunction

  logic [7:0]             divCnt;
  irqpe_pkg::irqpe_phase_t phase;
  logic                   secondMachineCycle;
  logic [7:0]             ieReg;
  logic [7:0]             ipReg;
  logic [1:0]             edgeSel;
  logic [3:0]             tconHi;
  logic                   maskTouched;
  logic                   highActive;
  logic                   lowActive;
  wire  logic [1:0]       extFlag;
  wire  logic [1:0]       extPin;
  wire  logic [1:0]       vecTakeExt;

  // Bit positions inside the timer control byte
  localparam int SEL0_BIT = irqpe_pkg::EXT_SEL_OFS;
  localparam int SEL1_BIT = irqpe_pkg::EXT_STRIDE + irqpe_pkg::EXT_SEL_OFS;
  localparam int HI_LSB   = irqpe_pkg::TIMER_CONTROL_REG_HI_LSB;
  localparam int BYTE_MSB = 7;

  // State divider: one enable pulse per machine-cycle state
  wire logic phaseTick = divCnt == 8'(PHASE_CLKS - 1);
  wire logic atS3 = phaseTick && phase == irqpe_pkg::PH_THREE;
  wire logic atS4 = phaseTick && phase == irqpe_pkg::PH_FOUR;
  wire logic atS5 = phaseTick && phase == irqpe_pkg::PH_FIVE;
  wire logic atS6 = phaseTick && phase == irqpe_pkg::PH_SIX;
  irqpe_pkg::irqpe_phase_t next_phase;
  assign next_phase = (phase == irqpe_pkg::PH_SIX) ? irqpe_pkg::PH_ONE
                    : irqpe_pkg::irqpe_phase_t'(phase + 3'b001);

  // Divider, state sequence and machine-cycle parity
  // Reset restarts at state one of the first machine cycle, so edge timing repeats
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divCnt             <= 8'h00;
      phase              <= irqpe_pkg::PH_ONE;
      secondMachineCycle <= 1'b0;
    end else begin
      divCnt <= phaseTick ? 8'h00 : divCnt + 8'h01;
      if (phaseTick) begin
        phase <= next_phase;
      end
      if (atS6) begin
        secondMachineCycle <= ~secondMachineCycle;
      end
    end
  end

  // APB decode: zero wait states, error on unmapped addresses
  wire logic setupPh = psel & ~penable;
  wire logic accessPh = psel & penable;
  wire logic hitTcon = paddr == irqpe_pkg::TIMER_CONTROL_REG_OFS;
  wire logic hitIe = paddr == irqpe_pkg::IE_OFS;
  wire logic hitIp = paddr == irqpe_pkg::IP_OFS;
  wire logic mapped = hitTcon | hitIe | hitIp;
  wire logic wrEn = accessPh & pwrite & mapped;
  wire logic wrTcon = wrEn & hitTcon;
  // A read of IE or IP never counts as touching the mask
  wire logic wrMask = wrEn & (hitIe | hitIp);
  assign pready  = 1'b1;
  assign pslverr = accessPh & ~mapped;

  // Read selection; reserved bit 6 of IE and IP reads one
  wire logic [7:0] tconView = {tconHi, extFlag[1], edgeSel[1], extFlag[0], edgeSel[0]};
  wire logic [7:0] readMux = hitTcon ? tconView
                           : hitIe   ? (ieReg | irqpe_pkg::RSV_ONES)
                           : hitIp   ? (ipReg | irqpe_pkg::RSV_ONES)
                           : 8'h00;

  // Read data is captured in the setup phase so it is stable in access
  // Limitation: a read shows the register as it stood at the setup edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setupPh & ~pwrite) begin
      prdata <= 32'(readMux);
    end
  end

  // Software-owned register bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ieReg   <= irqpe_pkg::IE_RST;
      ipReg   <= irqpe_pkg::IP_RST;
      edgeSel <= {irqpe_pkg::TIMER_CONTROL_REG_RST[SEL1_BIT], irqpe_pkg::TIMER_CONTROL_REG_RST[SEL0_BIT]};
      tconHi  <= irqpe_pkg::TIMER_CONTROL_REG_RST[BYTE_MSB:HI_LSB];
    end else begin
      if (wrEn & hitIe) begin
        ieReg <= pwdata[7:0];
      end
      if (wrEn & hitIp) begin
        ipReg <= pwdata[7:0];
      end
      if (wrTcon) begin
        edgeSel <= {pwdata[SEL1_BIT], pwdata[SEL0_BIT]};
        tconHi  <= pwdata[BYTE_MSB:HI_LSB];
      end
    end
  end

  assign extPin = {ext1Pin, ext0Pin};

  // One detector per external pin; the S5 latch serves both modes
  // Limitation: a pin pulse shorter than one machine cycle may be missed
  for (genvar i = 0; i < irqpe_pkg::NUM_EXT; i++) begin : g_ext
    localparam int FLAG_BIT = i * irqpe_pkg::EXT_STRIDE + irqpe_pkg::EXT_FLAG_OFS;
    logic stage1;
    logic stage2;
    logic edgeHold;
    logic flag;
    // Falling edge seen by the S5 latch since the previous S3; it needs
    // the latch to read high first, so a held low pin fires only once
    wire logic edgePulse = atS3 & stage1 & ~stage2;
    wire logic m2S3 = atS3 & secondMachineCycle;
    wire logic setEv = edgeSel[i] ? (m2S3 & (edgeHold | edgePulse))
                                  : (atS3 & stage1);
    wire logic swSet = wrTcon & pwdata[FLAG_BIT];
    wire logic swClr = wrTcon & ~pwdata[FLAG_BIT];
    // Level flag only lives from S3 to S6, so it mirrors the pin
    wire logic clrEv = (~edgeSel[i] & atS6)
                     | (edgeSel[i] & vecTakeExt[i])
                     | swClr;

    // Pin latch, second stage and set/reset edge store
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        stage1   <= 1'b0;
        stage2   <= 1'b0;
        edgeHold <= 1'b0;
      end else begin
        if (atS5) begin
          stage1 <= ~extPin[i];
        end
        if (atS3) begin
          stage2 <= stage1;
        end
        if (edgePulse) begin
          edgeHold <= 1'b1;
        end else if (atS4 & secondMachineCycle) begin
          edgeHold <= 1'b0;
        end
      end
    end

    // Request flag: a hardware set wins over any clear in the same cycle
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        flag <= irqpe_pkg::TIMER_CONTROL_REG_RST[FLAG_BIT];
      end else if (setEv | swSet) begin
        flag <= 1'b1;
      end else if (clrEv) begin
        flag <= 1'b0;
      end
    end
    assign extFlag[i] = flag;
  end

  // Source vector in fixed preference order, index 0 first
  wire logic [5:0] reqVec = {timer2Req, serialReq, timer1Req,
                             extFlag[1], timer0Req, extFlag[0]};
  wire logic globalEn = ieReg[irqpe_pkg::GLOBAL_EN_BIT];
  wire logic [5:0] enabled = reqVec & ieReg[5:0] & {6{globalEn}};
  wire logic bypass = ipReg[irqpe_pkg::BYPASS_BIT];
  wire logic [5:0] prioBits = ipReg[5:0];
  // Uniform priority bits give one level, same as bypass ordering
  wire logic singleLevel = bypass | prioBits == irqpe_pkg::SRC_NONE
                         | prioBits == irqpe_pkg::SRC_ALL;
  wire logic [5:0] effHigh = singleLevel ? irqpe_pkg::SRC_NONE : prioBits;
  wire logic [3:0] hiPick = pickFirst(enabled & effHigh);
  wire logic [3:0] loPick = pickFirst(enabled & ~effHigh);

  // A high request may suspend a low routine, nothing preempts a high one
  wire logic canHigh = hiPick[3] & ~highActive;
  // A low routine in service blocks every other request at one level
  wire logic canLow = loPick[3] & ~highActive & ~lowActive;
  // Bypass: software alone decides nesting through the enables
  wire logic reqOk = bypass ? loPick[3] : (canHigh | canLow);
  wire logic [2:0] pickSrc = (~bypass & canHigh) ? hiPick[2:0] : loPick[2:0];

  // Mask write by the instruction itself or over APB during it
  wire logic touchedNow = seq.writesMask | wrMask | maskTouched;
  // Blocking only the boundary of a touching or return instruction
  // lets exactly one more instruction run before the call
  wire logic blockNow = touchedNow | seq.isReti;
  wire logic take = seq.instrDone & reqOk & ~blockNow;
  // Edge flags clear only for the source actually called
  assign vecTakeExt = {take & (pickSrc == extSrc(1)),
                       take & (pickSrc == extSrc(0))};

  // Remember APB mask writes until the current instruction ends
  // Hazard: a write landing with the boundary itself blocks only that
  // boundary; the held flag is cleared there, so the next one is free
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      maskTouched <= 1'b0;
    end else if (seq.instrDone) begin
      maskTouched <= 1'b0;
    end else if (wrMask) begin
      maskTouched <= 1'b1;
    end
  end

  // In-service levels; a return closes the higher level first
  // In bypass the levels are still tracked but never block; software nests
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      highActive <= 1'b0;
      lowActive  <= 1'b0;
    end else if (take) begin
      if (effHigh[pickSrc]) begin
        highActive <= 1'b1;
      end else begin
        lowActive <= 1'b1;
      end
    end else if (seq.instrDone & seq.isReti) begin
      if (highActive) begin
        highActive <= 1'b0;
      end else begin
        lowActive <= 1'b0;
      end
    end
  end

  // Vector call pulse in the cycle after the instruction end
  // Source and level register beside valid so the word is coherent
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      vec <= '0;
    end else begin
      vec.valid  <= take;
      vec.source <= pickSrc;
      vec.high   <= effHigh[pickSrc];
    end
  end

  assign inService = {highActive, lowActive};

endmodule // irqpe_core

// ==== design/irqpe_pkg.sv ====
// Constants and carrier types for the interrupt priority and
// external detect block. Assumes one clock and an APB register bus.
package irqpe_pkg;
  // Register byte addresses on the APB bus
  localparam logic [7:0] TIMER_CONTROL_REG_OFS = 8'h88;
  localparam logic [7:0] IE_OFS   = 8'ha8;
  localparam logic [7:0] IP_OFS   = 8'hb8;
  // Reset values and read-as-one reserved bit
  localparam logic [7:0] TIMER_CONTROL_REG_RST = 8'h00;
  localparam logic [7:0] IE_RST   = 8'h00;
  localparam logic [7:0] IP_RST   = 8'h00;
  localparam logic [7:0] RSV_ONES = 8'h40;
  // Field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int BYPASS_BIT    = 7;
  localparam int EXT_STRIDE    = 2;  // Per external input: select, flag
  localparam int EXT_SEL_OFS   = 0;
  localparam int EXT_FLAG_OFS  = 1;
  localparam int TIMER_CONTROL_REG_HI_LSB   = 4;
  localparam int NUM_SRC       = 6;
  localparam int NUM_EXT       = 2;
  localparam int SRC_W         = 3;
  localparam logic [5:0] SRC_ALL = 6'h3f;
  localparam logic [5:0] SRC_NONE = 6'h00;
  // Clock cycles per machine-cycle state (one cycle per oscillator period)
  localparam int PHASE_CLKS = 2;

  // Machine-cycle states one to six
  typedef enum logic [2:0] {
    PH_ONE   = 3'b000,
    PH_TWO   = 3'b001,
    PH_THREE = 3'b010,
    PH_FOUR  = 3'b011,
    PH_FIVE  = 3'b100,
    PH_SIX   = 3'b101
  } irqpe_phase_t;

  // Instruction boundary report from the sequencer
  typedef struct packed {
    logic instrDone;
    logic writesMask;
    logic isReti;
  } irqpe_seq_t;

  // Vector call request towards the sequencer
  typedef struct packed {
    logic             valid;
    logic [SRC_W-1:0] source;
    logic             high;
  } irqpe_vec_t;
endpackage

// ==== verification/irqpe_chk.sv ====
// Port-level checks for the interrupt arbitration block.
// Assumes one clock, synchronous active-high reset, zero-wait APB.
module irqpe_chk #(
  parameter int PHASE_CLKS = 2
) (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire irqpe_pkg::irqpe_seq_t seq,
  input wire irqpe_pkg::irqpe_vec_t vec,
  input wire logic [1:0]            inService
);
  logic [7:0] ieSh;
  logic [7:0] ipSh;
  // Bus decode; a write lands only where pready is sampled high
  wire apbWr  = psel && penable && pwrite && pready;
  wire mapped = paddr == irqpe_pkg::TIMER_CONTROL_REG_OFS || paddr == irqpe_pkg::IE_OFS ||
                paddr == irqpe_pkg::IP_OFS;
  // Shadow enable and priority, so gating can be judged from the ports
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ieSh <= 8'h00;
      ipSh <= 8'h00;
    end else if (apbWr && paddr == irqpe_pkg::IE_OFS) begin
      ieSh <= pwdata[7:0];
    end else if (apbWr && paddr == irqpe_pkg::IP_OFS) begin
      ipSh <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Boundaries that must not vector, and the single-level blocking case
  sequence s_deferred;
    seq.instrDone && (seq.writesMask || seq.isReti);
  endsequence
  sequence s_one_level;
    seq.instrDone && inService != 2'b00 && !ipSh[7] &&
    (ipSh[5:0] == 6'h00 || ipSh[5:0] == 6'h3f);
  endsequence
  a_vec_pulse: assert property (vec.valid |=> !vec.valid)
    else $error("vector valid held past one cycle");
  a_vec_boundary: assert property (vec.valid |-> $past(seq.instrDone))
    else $error("vector without an instruction end");
  a_masked_defer: assert property (s_deferred |=> !vec.valid)
    else $error("vector right after a mask write or return");
  a_global_gate: assert property (seq.instrDone && !ieSh[7] |=> !vec.valid)
    else $error("vector with global enable clear");
  a_enabled_only: assert property (vec.valid |-> ieSh[7] && ieSh[vec.source])
    else $error("vector for a disabled source");
  a_single_level: assert property (s_one_level |=> !vec.valid)
    else $error("nested vector with a single level");
  a_high_preempt: assert property (vec.valid && $past(inService) == 2'b01 && !ipSh[7]
    |-> vec.high)
    else $error("low routine suspended by a low request");
  a_err_map: assert property (psel && penable |-> pslverr == !mapped)
    else $error("bus error flag does not match the map");
endmodule // irqpe_chk

bind irqpe_core irqpe_chk #(.PHASE_CLKS(PHASE_CLKS)) u_chk (.clk_sys, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .seq, .vec, .inService);

// ==== verification/irqpe_seq_model.sv ====
// Behavioural instruction sequencer and external pin source.
// Assumes the bench calls its tasks; clk_sys runs freely.
module irqpe_seq_model (
  input wire logic              clk_sys,
  output irqpe_pkg::irqpe_seq_t seq,
  output logic                  ext0Pin,
  output logic                  ext1Pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: no boundary, both pins inactive high
  initial begin
    seq = '0;
    ext0Pin = 1'b1;
    ext1Pin = 1'b1;
  end
  // One instruction end, a single-cycle pulse with its qualifiers
  task automatic instr(input logic wm, input logic rt);
    @(posedge clk_sys);
    seq <= '{1'b1, wm, rt};
    @(posedge clk_sys);
    seq <= '0;
  endtask
  // Pin level then a hold; callers keep holds well above twelve periods
  task automatic pin(input int i, input logic v, input int n);
    @(posedge clk_sys);
    if (i == 0) ext0Pin <= v;
    else ext1Pin <= v;
    repeat (n) @(posedge clk_sys);
  endtask
endmodule // irqpe_seq_model

// ==== verification/test_irq_priority_and_ext_detect.sv ====
// Self-checking bench for the interrupt arbitration block.
// Assumes zero-wait APB and the sequencer model for boundaries and pins.
module test_irq_priority_and_ext_detect;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] ie; logic [7:0] ip; logic [5:0] rq; logic [3:0] ex;} irqpe_row_t;
  logic                  clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0, prdata, q;
  logic                  pready, pslverr, err, ext0Pin, ext1Pin;
  logic [5:0]            req = 6'h00;
  logic [1:0]            inService;
  logic [3:0]            got;
  irqpe_pkg::irqpe_seq_t seq;
  irqpe_pkg::irqpe_vec_t vec;
  int                    errors = 0, num_checks = 0;
  // Each row: enables, priorities, requests by source index, expected {valid,source}
  irqpe_row_t rows [11] = '{'{8'hbf, 8'h00, 6'h3f, 4'h8}, '{8'hbf, 8'h3f, 6'h3f, 4'h8},
    '{8'hbf, 8'h00, 6'h3e, 4'h9}, '{8'hbf, 8'h00, 6'h3c, 4'ha}, '{8'hbf, 8'h00, 6'h38, 4'hb},
    '{8'hbf, 8'h00, 6'h30, 4'hc}, '{8'hbf, 8'h00, 6'h20, 4'hd}, '{8'hbf, 8'h20, 6'h21, 4'hd},
    '{8'hbf, 8'h80, 6'h3f, 4'h8}, '{8'ha0, 8'h80, 6'h3f, 4'hd}, '{8'h3f, 8'h00, 6'h3f, 4'h0}};
  logic [7:0] adr [3] = '{irqpe_pkg::TIMER_CONTROL_REG_OFS, irqpe_pkg::IE_OFS, irqpe_pkg::IP_OFS};
  logic [7:0] rv [3] = '{irqpe_pkg::TIMER_CONTROL_REG_RST, irqpe_pkg::IE_RST | irqpe_pkg::RSV_ONES,
    irqpe_pkg::IP_RST | irqpe_pkg::RSV_ONES};
  logic [7:0] bv [3] = '{8'hb5, 8'hf5, 8'hf5};
  // Design and its far side; ext pins live in the model
  irqpe_core #(.PHASE_CLKS(2)) u_dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ext0Pin, .ext1Pin, .timer0Req(req[1]), .timer1Req(req[3]),
    .serialReq(req[4]), .timer2Req(req[5]), .seq, .vec, .inService);
  irqpe_seq_model u_seq (.clk_sys, .seq, .ext0Pin, .ext1Pin);
  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    req <= 6'h00;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
  endtask
  // Setup then access, held until pready is sampled high; result in q and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One boundary; the vector must show one cycle after the taken edge
  task automatic bnd(input logic wm, input logic rt, input logic [3:0] ex);
    u_seq.instr(wm, rt);
    @(negedge clk_sys);
    check("vector", {vec.valid, vec.valid ? vec.source : 3'h0}, ex);
  endtask
  // Timer 2 in service at the lower level, then timer 0 arrives
  task automatic nest(input logic [7:0] ip, input logic [3:0] ex, input logic [1:0] sv);
    do_reset();
    req <= 6'h20;
    apb(1'b1, irqpe_pkg::IP_OFS, {24'h0, ip});
    apb(1'b1, irqpe_pkg::IE_OFS, 32'ha2);
    bnd(1'b1, 1'b0, 4'h0);
    bnd(1'b0, 1'b0, 4'hd);
    @(posedge clk_sys);
    req <= 6'h02;
    apb(1'b1, irqpe_pkg::IE_OFS, 32'h00);
    apb(1'b1, irqpe_pkg::IE_OFS, 32'h82);
    bnd(1'b0, 1'b0, 4'h0);
    bnd(1'b0, 1'b0, ex);
    check("in service", inService, {30'h0, sv});
  endtask
  // Watchdog, far beyond the roughly twelve hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    complete_run();
  end
  // Main sequence
  initial begin
    do_reset();
    for (int a = 0; a < 3; a++) begin
      apb(1'b0, adr[a], 32'h0);
      check("reset value", q, {24'h0, rv[a]});
      apb(1'b1, adr[a], 32'hb5);
      apb(1'b0, adr[a], 32'h0);
      check("read back", q, {24'h0, bv[a]});
    end
    apb(1'b1, 8'h90, 32'hff);
    check("unmapped error", err, 32'h1);
    apb(1'b0, 8'h90, 32'h0);
    check("unmapped data", q, 32'h0);
    $display("done: registers");
    foreach (rows[n]) begin
      do_reset();
      apb(1'b1, irqpe_pkg::TIMER_CONTROL_REG_OFS, {28'h0, rows[n].rq[2], 1'b1, rows[n].rq[0], 1'b1});
      req <= rows[n].rq;
      apb(1'b1, irqpe_pkg::IP_OFS, {24'h0, rows[n].ip});
      apb(1'b1, irqpe_pkg::IE_OFS, {24'h0, rows[n].ie});
      bnd(1'b1, 1'b0, 4'h0);
      bnd(1'b0, 1'b0, rows[n].ex);
    end
    $display("done: arbitration table");
    nest(8'h00, 4'h0, 2'b01);
    nest(8'h3f, 4'h0, 2'b01);
    nest(8'h02, 4'h9, 2'b11);
    nest(8'h80, 4'h9, 2'b01);
    $display("done: nesting");
    do_reset();
    req <= 6'h20;
    apb(1'b1, irqpe_pkg::IE_OFS, 32'ha0);
    bnd(1'b0, 1'b0, 4'h0);
    bnd(1'b1, 1'b0, 4'h0);
    bnd(1'b0, 1'b0, 4'hd);
    bnd(1'b0, 1'b1, 4'h0);
    bnd(1'b0, 1'b0, 4'hd);
    bnd(1'b0, 1'b1, 4'h0);
    bnd(1'b1, 1'b0, 4'h0);
    bnd(1'b0, 1'b0, 4'hd);
    $display("done: latency");
    for (int i = 0; i < 2; i++) begin
      do_reset();
      apb(1'b1, irqpe_pkg::TIMER_CONTROL_REG_OFS, i ? 32'h04 : 32'h01);
      apb(1'b1, irqpe_pkg::IE_OFS, i ? 32'h84 : 32'h81);
      u_seq.pin(i, 1'b0, 50);
      apb(1'b0, irqpe_pkg::TIMER_CONTROL_REG_OFS, 32'h0);
      check("edge flag", q, i ? 32'h0c : 32'h03);
      bnd(1'b0, 1'b0, 4'h0);
      bnd(1'b0, 1'b0, i ? 4'ha : 4'h8);
      apb(1'b0, irqpe_pkg::TIMER_CONTROL_REG_OFS, 32'h0);
      check("edge clear", q, i ? 32'h04 : 32'h01);
      bnd(1'b0, 1'b1, 4'h0);
      u_seq.pin(i, 1'b0, 50);
      bnd(1'b0, 1'b0, 4'h0);
      u_seq.pin(i, 1'b1, 30);
      u_seq.pin(i, 1'b0, 50);
      apb(1'b0, irqpe_pkg::TIMER_CONTROL_REG_OFS, 32'h0);
      check("edge rearm", q, i ? 32'h0c : 32'h03);
      u_seq.pin(i, 1'b1, 30);
    end
    $display("done: edge detect");
    for (int i = 0; i < 2; i++) begin
      do_reset();
      apb(1'b1, irqpe_pkg::IE_OFS, i ? 32'h84 : 32'h81);
      u_seq.pin(i, 1'b0, 30);
      got = 4'h0;
      // The level flag lives only part of each machine cycle, so poll
      for (int k = 0; k < 20 && got[3] !== 1'b1; k++) begin
        u_seq.instr(1'b0, 1'b0);
        @(negedge clk_sys);
        if (vec.valid === 1'b1) got = {1'b1, vec.source};
      end
      check("level vector", got, i ? 32'ha : 32'h8);
      u_seq.pin(i, 1'b1, 30);
      bnd(1'b0, 1'b1, 4'h0);
      repeat (6) bnd(1'b0, 1'b0, 4'h0);
    end
    $display("done: level detect");
    complete_run();
  end
endmodule // test_irq_priority_and_ext_detect
